/* core/drm_pkg.sv */
package drm_pkg;

  // apb register byte offsets
  localparam logic [7:0] ADDR_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_SETUP = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_TX_RING_PTR = 8'h0C;
  localparam logic [7:0] ADDR_RX_RING_PTR = 8'h10;
  localparam logic [7:0] ADDR_TX_DESC01 = 8'h14;
  localparam logic [7:0] ADDR_TX_DESC2 = 8'h18;
  localparam logic [7:0] ADDR_RX_DESC01 = 8'h1C;
  localparam logic [7:0] ADDR_RX_DESC2 = 8'h20;

  // control_register_zero bits
  localparam int CTL_INIT_BIT = 0;
  localparam int CTL_RUN_START_BIT = 1;
  localparam int CTL_STOP_BIT = 2;

  // ring pointer fields
  localparam int PTR_LEN_HI = 31;
  localparam int PTR_LEN_LO = 29;
  localparam int PTR_BASE_HI = 23;
  localparam int PTR_BASE_LO = 3;

  // descriptor word one fields, and the top bit of the word two length field
  localparam int D1_HOLDER_BIT = 15;
  localparam int D1_ERR_BIT = 14;
  localparam int D1_FIRST_BIT = 9;
  localparam int D1_LAST_BIT = 8;
  localparam int D1_ADDR_HI = 7;
  localparam int BUFFER_LENGTH_NEGATED_HI = 11;

  // holder flag encoding
  localparam logic HOLDER_HOST = 1'b0;
  localparam logic HOLDER_DEVICE = 1'b1;

  // setup ring byte offset, word indices in 16-bit words, and ring channels
  localparam logic [1:0] SETUP_RING_WORD0 = 2'h0;
  localparam logic [4:0] SETUP_RING_OFFSET = 5'h10;
  localparam logic [1:0] DESC_WORD0 = 2'h0;
  localparam logic [1:0] DESC_WORD1 = 2'h1;
  localparam logic [1:0] DESC_WORD2 = 2'h2;
  localparam logic CH_TX = 1'b0;
  localparam logic CH_RX = 1'b1;
  localparam logic [23:0] SETUP_ADDR_RESET = 24'h000000;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_INIT = 3'h1,
    ST_POLL = 3'h2,
    ST_FETCH = 3'h3,
    ST_WBACK = 3'h4
  } drm_state_e;

  typedef struct packed {
    logic req;
    logic we;
    logic [23:0] addr;
    logic [15:0] wdata;
  } drm_mem_req_s;

  typedef struct packed {
    logic valid;
    logic [23:0] addr;
    logic [11:0] len;
    logic first;
    logic last;
  } drm_buf_s;

  typedef struct packed {
    drm_state_e st;
    logic run;
    logic inited;
    logic init_req;
    logic [23:0] setup_addr;
    logic [1:0] word;
    logic ch;
    drm_mem_req_s mem;
    logic [1:0][31:0] ring_ptr;
    logic [1:0][6:0] idx;
    logic [1:0] held;
    logic [1:0] wback;
    logic [1:0] err;
    logic [1:0][15:0] d0;
    logic [1:0][15:0] d1;
    logic [1:0][15:0] d2;
  } drm_state_s;

endpackage

/* core/drm_ring_manager.sv */
`timescale 1ns/1ps
// What this block does
// - transmit ring size field 31:29 decodes as two to that power entries
// - ring base is pointer bits 23:3; low three bits forced to zero
// - separate rx and tx rings; entry is four 16-bit words, lowest first
// - poll rings, hand tx buffers to channel, rx buffers to be filled
// - only the current entry is examined, never further ahead
// - ring locations and sizes come only from the setup block load
// - run start bit in control register zero begins ring polling
// - hand over only by clearing holder flag; never seize an entry
// - no field touched after handing an entry back to the host
// - device writes status into word one of entries it holds
// - word zero, low address bits, never written by the device
// - word one bits 7:0 high address bits, preserved by the device
// - word one bit 9 first buffer, bit 8 last buffer
// - word two 11:0 is negated buffer length; never written
// - tx entry held but not first is skipped; polling continues
// - tx first and last flags set by host, kept by the device
// - holder flag zero means host, one means device
module drm_ring_manager
  import drm_pkg::*;
(
  // clock and reset
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // bus-master memory port, 16-bit words
  output drm_mem_req_s mem_o,
  input wire logic mem_ack_i,
  input wire logic [15:0] mem_rdata_i,
  // transmit channel side
  output drm_buf_s tx_buf_o,
  input wire logic tx_buf_done_i,
  input wire logic tx_buf_err_i,
  // receive channel side
  input wire logic rx_buf_req_i,
  output drm_buf_s rx_buf_o,
  input wire logic rx_buf_done_i,
  input wire logic rx_buf_err_i,
  // state
  output logic running_o
);

  drm_state_s r;
  drm_state_s next_r;

  function automatic logic [23:0] ring_base(input logic [31:0] ptr);
    ring_base = {ptr[PTR_BASE_HI:PTR_BASE_LO], 3'h0};
  endfunction

  function automatic logic [23:0] desc_addr(input logic [31:0] ptr, input logic [6:0] idx,
                                            input logic [1:0] w);
    // eight bytes per entry, word w at base plus 2w
    desc_addr = ring_base(ptr) + {14'h0000, idx, 3'h0} + {21'h000000, w, 1'b0};
  endfunction

  function automatic logic [6:0] next_idx(input logic [31:0] ptr, input logic [6:0] idx);
    logic [7:0] last;
    last = (8'h01 << ptr[PTR_LEN_HI:PTR_LEN_LO]) - 8'h01;
    next_idx = ({1'b0, idx} == last) ? 7'h00 : 7'(idx + 7'h01);
  endfunction

  function automatic logic [11:0] buf_len(input logic [15:0] w2);
    buf_len = 12'(~w2[BUFFER_LENGTH_NEGATED_HI:0] + 12'h001);
  endfunction

  function automatic drm_buf_s buf_view(input drm_state_s s, input logic ch);
    buf_view.valid = s.held[ch] & ~s.wback[ch];
    buf_view.addr = {s.d1[ch][D1_ADDR_HI:0], s.d0[ch]};
    buf_view.len = buf_len(s.d2[ch]);
    buf_view.first = s.d1[ch][D1_FIRST_BIT];
    buf_view.last = s.d1[ch][D1_LAST_BIT];
  endfunction

  logic apb_wr;
  logic apb_hit;
  logic mem_done;

  assign apb_wr = psel_i & penable_i & pwrite_i;
  assign mem_done = r.mem.req & mem_ack_i;

  always_comb begin
    next_r = r;

    // channel completion: hardware set, cleared by the write-back, a setup load or stop
    if (r.held[CH_TX] && !r.wback[CH_TX] && tx_buf_done_i) begin
      next_r.wback[CH_TX] = 1'b1;
      next_r.err[CH_TX] = tx_buf_err_i;
    end
    if (r.held[CH_RX] && !r.wback[CH_RX] && rx_buf_done_i) begin
      next_r.wback[CH_RX] = 1'b1;
      next_r.err[CH_RX] = rx_buf_err_i;
    end

    unique case (r.st)
      ST_IDLE: begin
        if (r.init_req) begin
          // setup load runs first, so run start given with it waits for valid rings
          next_r.init_req = 1'b0;
          next_r.inited = 1'b0;
          next_r.word = SETUP_RING_WORD0;
          next_r.mem.req = 1'b1;
          next_r.mem.we = 1'b0;
          next_r.mem.addr = r.setup_addr + {19'h00000, SETUP_RING_OFFSET};
          next_r.st = ST_INIT;
        end else if (r.run && r.inited) begin
          next_r.st = ST_POLL;
        end
      end

      ST_INIT: begin
        if (mem_done) begin
          // rx pointer low/high then tx pointer low/high
          unique case (r.word)
            2'h0: next_r.ring_ptr[CH_RX][15:0] = mem_rdata_i;
            2'h1: next_r.ring_ptr[CH_RX][31:16] = mem_rdata_i;
            2'h2: next_r.ring_ptr[CH_TX][15:0] = mem_rdata_i;
            2'h3: next_r.ring_ptr[CH_TX][31:16] = mem_rdata_i;
          endcase
          if (r.word == 2'h3) begin
            next_r.mem.req = 1'b0;
            next_r.inited = 1'b1;
            next_r.idx = '0;
            next_r.held = '0;
            next_r.wback = '0;
            next_r.st = ST_IDLE;
          end else begin
            next_r.word = 2'(r.word + 2'h1);
            next_r.mem.addr = 24'(r.mem.addr + 24'h000002);
          end
        end
      end

      ST_POLL: begin
        // write-backs first so entries return to the host promptly
        if (!r.run) begin
          next_r.st = ST_IDLE;
        end else if (r.wback[CH_TX] || r.wback[CH_RX]) begin
          next_r.ch = r.wback[CH_TX] ? CH_TX : CH_RX;
          next_r.mem.req = 1'b1;
          next_r.mem.we = 1'b1;
          next_r.mem.addr = r.wback[CH_TX]
            ? desc_addr(r.ring_ptr[CH_TX], r.idx[CH_TX], DESC_WORD1)
            : desc_addr(r.ring_ptr[CH_RX], r.idx[CH_RX], DESC_WORD1);
          next_r.st = ST_WBACK;
        end else if (!r.held[CH_RX] && rx_buf_req_i) begin
          next_r.ch = CH_RX;
          next_r.word = DESC_WORD1;
          next_r.mem.req = 1'b1;
          next_r.mem.we = 1'b0;
          next_r.mem.addr = desc_addr(r.ring_ptr[CH_RX], r.idx[CH_RX], DESC_WORD1);
          next_r.st = ST_FETCH;
        end else if (!r.held[CH_TX]) begin
          // tx ring is polled continuously while no tx entry is held
          next_r.ch = CH_TX;
          next_r.word = DESC_WORD1;
          next_r.mem.req = 1'b1;
          next_r.mem.we = 1'b0;
          next_r.mem.addr = desc_addr(r.ring_ptr[CH_TX], r.idx[CH_TX], DESC_WORD1);
          next_r.st = ST_FETCH;
        end
      end

      ST_FETCH: begin
        if (mem_done) begin
          unique case (r.word)
            DESC_WORD1: begin
              next_r.d1[r.ch] = mem_rdata_i;
              if (mem_rdata_i[D1_HOLDER_BIT] == HOLDER_HOST) begin
                // host still holds it: leave untouched, try again later
                next_r.mem.req = 1'b0;
                next_r.st = ST_POLL;
              end else if (r.ch == CH_TX && !mem_rdata_i[D1_FIRST_BIT]) begin
                // stray middle buffer: step past it without writing
                next_r.mem.req = 1'b0;
                next_r.idx[CH_TX] = next_idx(r.ring_ptr[CH_TX], r.idx[CH_TX]);
                next_r.st = ST_POLL;
              end else begin
                next_r.word = DESC_WORD0;
                next_r.mem.addr = desc_addr(r.ring_ptr[r.ch], r.idx[r.ch], DESC_WORD0);
              end
            end
            DESC_WORD0: begin
              next_r.d0[r.ch] = mem_rdata_i;
              next_r.word = DESC_WORD2;
              next_r.mem.addr = desc_addr(r.ring_ptr[r.ch], r.idx[r.ch], DESC_WORD2);
            end
            default: begin
              next_r.d2[r.ch] = mem_rdata_i;
              next_r.mem.req = 1'b0;
              next_r.held[r.ch] = 1'b1;
              next_r.err[r.ch] = 1'b0;
              next_r.st = ST_POLL;
            end
          endcase
        end
      end

      ST_WBACK: begin
        if (mem_done) begin
          // entry now belongs to the host; only the index moves on
          next_r.mem.req = 1'b0;
          next_r.mem.we = 1'b0;
          next_r.held[r.ch] = 1'b0;
          next_r.wback[r.ch] = 1'b0;
          next_r.idx[r.ch] = next_idx(r.ring_ptr[r.ch], r.idx[r.ch]);
          next_r.st = ST_POLL;
        end
      end

      default: begin
        next_r.mem.req = 1'b0;
        next_r.st = ST_IDLE;
      end
    endcase

    // status write-back word: holder cleared, bits 9:0 go back exactly as fetched
    next_r.mem.wdata = {HOLDER_HOST, r.err[r.ch], 4'h0,
                        r.d1[r.ch][D1_FIRST_BIT:0]};

    // register writes; stop aborts everything including a pending bus access
    if (apb_wr && paddr_i == ADDR_CONTROL) begin
      if (pwdata_i[CTL_STOP_BIT]) begin
        next_r.run = 1'b0;
        next_r.inited = 1'b0;
        next_r.init_req = 1'b0;
        next_r.held = '0;
        next_r.wback = '0;
        next_r.idx = '0;
        next_r.mem.req = 1'b0;
        next_r.mem.we = 1'b0;
        next_r.st = ST_IDLE;
      end else begin
        if (pwdata_i[CTL_INIT_BIT]) begin
          next_r.init_req = 1'b1;
        end
        if (pwdata_i[CTL_RUN_START_BIT]) begin
          next_r.run = 1'b1;
        end
      end
    end
    if (apb_wr && paddr_i == ADDR_SETUP) begin
      next_r.setup_addr = {pwdata_i[23:1], 1'b0};
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      r <= '0;
      r.st <= ST_IDLE;
      r.setup_addr <= SETUP_ADDR_RESET;
    end else begin
      r <= next_r;
    end
  end

  // apb read mux; zero wait states, unmapped addresses answer with an error
  always_comb begin
    prdata_o = 32'h00000000;
    apb_hit = 1'b1;
    unique case (paddr_i)
      ADDR_CONTROL: prdata_o = {29'h00000000, 1'b0, r.run, r.init_req};
      ADDR_SETUP: prdata_o = {8'h00, r.setup_addr};
      ADDR_STATUS: prdata_o = {3'h0, r.idx[CH_RX], 1'b0, r.idx[CH_TX], 5'h00, r.st,
                               r.wback, r.held, r.run & r.inited, r.inited};
      ADDR_TX_RING_PTR: prdata_o = r.ring_ptr[CH_TX];
      ADDR_RX_RING_PTR: prdata_o = r.ring_ptr[CH_RX];
      ADDR_TX_DESC01: prdata_o = {r.d1[CH_TX], r.d0[CH_TX]};
      ADDR_TX_DESC2: prdata_o = {16'h0000, r.d2[CH_TX]};
      ADDR_RX_DESC01: prdata_o = {r.d1[CH_RX], r.d0[CH_RX]};
      ADDR_RX_DESC2: prdata_o = {16'h0000, r.d2[CH_RX]};
      default: apb_hit = 1'b0;
    endcase
  end

  assign pready_o = 1'b1;
  assign pslverr_o = psel_i & penable_i & ~apb_hit;
  assign mem_o = r.mem;
  assign tx_buf_o = buf_view(r, CH_TX);
  assign rx_buf_o = buf_view(r, CH_RX);
  assign running_o = r.run & r.inited;

endmodule // drm_ring_manager

/* sim/drm_host_mem.sv */
`timescale 1ns/1ps
module drm_host_mem
  import drm_pkg::*;
(
  // clock and reset
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  // device memory port
  input wire drm_mem_req_s mem_i,
  input wire logic stall_i,
  output logic mem_ack_o,
  output logic [15:0] mem_rdata_o
);
  // 16-bit words, lowest address first; the bench writes host entries here
  logic [15:0] mem [0:511];
  always @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mem_ack_o <= 1'b0;
    end else begin
      // one pulse per request; stall_i gives slow answers
      mem_ack_o <= mem_i.req && !mem_ack_o && !stall_i;
      if (mem_i.req && mem_i.we && mem_ack_o) begin
        mem[mem_i.addr[9:1]] <= mem_i.wdata;
      end
    end
  end
  // outside the ack cycle the bus shows inverted data, never stale data
  assign mem_rdata_o = mem_ack_o ? mem[mem_i.addr[9:1]] : ~mem[mem_i.addr[9:1]];
endmodule // drm_host_mem

/* sim/drm_ring_manager_sva.sv */
`timescale 1ns/1ps
module drm_ring_manager_sva
  import drm_pkg::*;
(
  // clock and reset
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  // apb
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic [7:0] paddr_i,
  input wire logic pready_o,
  input wire logic pslverr_o,
  // memory and channels
  input wire drm_mem_req_s mem_o,
  input wire logic mem_ack_i,
  input wire drm_buf_s tx_buf_o,
  input wire logic tx_buf_done_i,
  input wire drm_buf_s rx_buf_o,
  input wire logic rx_buf_done_i,
  input wire logic running_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!arst_n_i);
  logic mapped;
  assign mapped = paddr_i inside {ADDR_CONTROL, ADDR_SETUP, ADDR_STATUS, ADDR_TX_RING_PTR,
    ADDR_RX_RING_PTR, ADDR_TX_DESC01, ADDR_TX_DESC2, ADDR_RX_DESC01, ADDR_RX_DESC2};
  sequence s_acc; psel_i && penable_i; endsequence
  sequence s_wb; mem_o.req && mem_o.we; endsequence
  sequence s_tx_done; tx_buf_o.valid && tx_buf_done_i && running_o; endsequence
  zero_wait_a: assert property (s_acc |-> pready_o) else $error("apb access stalled");
  unmapped_err_a: assert property (psel_i && penable_i && !mapped |-> pslverr_o)
    else $error("unmapped access without error");
  mapped_ok_a: assert property (psel_i && penable_i && mapped |-> !pslverr_o)
    else $error("mapped access flagged");
  req_hold_a: assert property (mem_o.req && !mem_ack_i |=>
    (mem_o.req && $stable(mem_o.addr) && $stable(mem_o.we)) || !running_o)
    else $error("memory request changed before ack");
  wb_word_a: assert property (s_wb |-> mem_o.addr[2:1] == DESC_WORD1)
    else $error("write outside word one");
  wb_status_a: assert property (s_wb |-> mem_o.wdata[15] == HOLDER_HOST &&
    mem_o.wdata[13:10] == 4'h0) else $error("bad status word");
  tx_drop_a: assert property (tx_buf_o.valid && tx_buf_done_i |=> !tx_buf_o.valid)
    else $error("tx buffer kept after done");
  rx_drop_a: assert property (rx_buf_o.valid && rx_buf_done_i |=> !rx_buf_o.valid)
    else $error("rx buffer kept after done");
  tx_first_a: assert property (tx_buf_o.valid |-> tx_buf_o.first)
    else $error("tx buffer without first flag");
  wback_due_a: assert property (s_tx_done |-> ##[1:60] s_wb)
    else $error("no status write after tx done");
endmodule // drm_ring_manager_sva

bind drm_ring_manager drm_ring_manager_sva u_sva (.core_clk_i, .arst_n_i, .psel_i, .penable_i,
  .paddr_i, .pready_o, .pslverr_o, .mem_o, .mem_ack_i, .tx_buf_o, .tx_buf_done_i, .rx_buf_o,
  .rx_buf_done_i, .running_o);

/* sim/testbench.sv */
`timescale 1ns/1ps
module testbench;
  import drm_pkg::*;
  localparam logic [31:0] TX_PTR = 32'h2000_0100;
  localparam logic [31:0] RX_PTR = 32'h0000_0200;
  logic core_clk_i, arst_n_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, mem_ack_i;
  logic tx_buf_done_i, tx_buf_err_i, rx_buf_req_i, rx_buf_done_i, rx_buf_err_i, running_o, stall;
  logic [7:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o, rd;
  logic [15:0] mem_rdata_i;
  logic er;
  drm_mem_req_s mem_o;
  drm_buf_s tx_buf_o, rx_buf_o;
  int seed = 65164;
  int err_count = 0;
  int checks = 0;
  int cyc = 0;

  drm_ring_manager u_drm_ring_manager (.core_clk_i, .arst_n_i, .psel_i, .penable_i, .pwrite_i,
    .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .mem_o, .mem_ack_i, .mem_rdata_i,
    .tx_buf_o, .tx_buf_done_i, .tx_buf_err_i, .rx_buf_req_i, .rx_buf_o, .rx_buf_done_i,
    .rx_buf_err_i, .running_o);
  drm_host_mem u_drm_host_mem (.core_clk_i, .arst_n_i, .mem_i(mem_o), .stall_i(stall),
    .mem_ack_o(mem_ack_i), .mem_rdata_o(mem_rdata_i));

  initial begin
    core_clk_i = 1'b0;
    forever #20 core_clk_i = ~core_clk_i;
  end

  always @(posedge core_clk_i) begin
    stall <= 1'($random(seed));
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      finish_test();
    end
  end

  function automatic logic [15:0] wb_word(input logic [15:0] w1, input logic e);
    return {HOLDER_HOST, e, 4'h0, w1[9:0]};
  endfunction

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge core_clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge core_clk_i);
    penable_i <= 1'b1;
    do @(posedge core_clk_i); while (pready_o !== 1'b1);
    r = prdata_o;
    e = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask

  // hand one entry to the device, take the buffer, then check the returned entry
  task automatic serve(input logic ch, input int wi);
    logic [23:0] a;
    logic [11:0] n;
    logic [15:0] w1;
    logic e;
    drm_buf_s b;
    a = 24'($random(seed));
    n = 12'h040 + 12'({$random(seed)} % 1900);
    e = 1'($random(seed));
    w1 = {HOLDER_DEVICE, 5'h00, 1'b1, n[0], a[23:16]};
    @(posedge core_clk_i);
    u_drm_host_mem.mem[wi] <= a[15:0];
    u_drm_host_mem.mem[wi + 2] <= {4'hF, -n};
    u_drm_host_mem.mem[wi + 1] <= w1;
    rx_buf_req_i <= ch;
    do begin
      @(posedge core_clk_i);
      b = ch ? rx_buf_o : tx_buf_o;
    end while (b.valid !== 1'b1);
    chk("buf_addr", 32'(a), 32'(b.addr));
    chk("buf_len", 32'(n), 32'(b.len));
    chk("buf_flags", {30'h0, w1[9:8]}, {30'h0, b.first, b.last});
    if (ch) begin
      rx_buf_done_i <= 1'b1;
      rx_buf_err_i <= e;
    end else begin
      tx_buf_done_i <= 1'b1;
      tx_buf_err_i <= e;
    end
    @(posedge core_clk_i);
    rx_buf_done_i <= 1'b0;
    tx_buf_done_i <= 1'b0;
    do @(posedge core_clk_i); while (u_drm_host_mem.mem[wi + 1][15] !== HOLDER_HOST);
    chk("word1", 32'(wb_word(w1, e)), 32'(u_drm_host_mem.mem[wi + 1]));
    chk("word0", 32'(a[15:0]), 32'(u_drm_host_mem.mem[wi]));
    chk("word2", 32'({4'hF, -n}), 32'(u_drm_host_mem.mem[wi + 2]));
  endtask

  task automatic finish_test();
    if (err_count == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  initial begin
    {psel_i, penable_i, pwrite_i, tx_buf_done_i, tx_buf_err_i} = 5'h00;
    {rx_buf_req_i, rx_buf_done_i, rx_buf_err_i, arst_n_i} = 4'h0;
    paddr_i = 8'h00;
    pwdata_i = 32'h0;
    // setup block at 0x40: ring pointers from byte offset 0x10
    u_drm_host_mem.mem[9'h028] = RX_PTR[15:0];
    u_drm_host_mem.mem[9'h029] = RX_PTR[31:16];
    u_drm_host_mem.mem[9'h02A] = TX_PTR[15:0];
    u_drm_host_mem.mem[9'h02B] = TX_PTR[31:16];
    // two tx entries: entry 0 device held without first flag, entry 1 host held
    u_drm_host_mem.mem[9'h080] = 16'h1234;
    u_drm_host_mem.mem[9'h081] = 16'h8100;
    u_drm_host_mem.mem[9'h082] = 16'hFFC0;
    u_drm_host_mem.mem[9'h085] = 16'h0000;
    u_drm_host_mem.mem[9'h101] = 16'h0000;
    repeat (5) @(posedge core_clk_i);
    arst_n_i <= 1'b1;
    apb(1'b0, 8'h3C, 32'h0, rd, er);
    chk("unmapped_err", 32'h1, {31'h0, er});
    apb(1'b1, ADDR_SETUP, 32'h0000_0040, rd, er);
    apb(1'b0, ADDR_SETUP, 32'h0, rd, er);
    chk("setup_addr", 32'h0000_0040, rd);
    chk("idle_run", 32'h0, {31'h0, running_o});
    apb(1'b1, ADDR_CONTROL, 32'h0000_0003, rd, er);
    while (running_o !== 1'b1) @(posedge core_clk_i);
    apb(1'b0, ADDR_TX_RING_PTR, 32'h0, rd, er);
    chk("tx_ring_ptr", TX_PTR, rd);
    apb(1'b0, ADDR_RX_RING_PTR, 32'h0, rd, er);
    chk("rx_ring_ptr", RX_PTR, rd);
    apb(1'b0, ADDR_STATUS, 32'h0, rd, er);
    chk("status_run", 32'h3, {26'h0, rd[5:0]});
    // each tx pass wraps through the skipped entry 0
    repeat (6) begin
      serve(CH_TX, 32'h84);
      serve(CH_RX, 32'h100);
    end
    chk("skipped_entry", 32'h8100, 32'(u_drm_host_mem.mem[9'h081]));
    apb(1'b1, ADDR_CONTROL, 32'h0000_0004, rd, er);
    @(posedge core_clk_i);
    chk("stopped", 32'h0, {31'h0, running_o});
    apb(1'b0, ADDR_STATUS, 32'h0, rd, er);
    chk("status_stop", 32'h0, rd);
    finish_test();
  end
endmodule // testbench
